// >>> inc/iopcb_pkg.sv
// Shared constants for the I/O port with clock blocks.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package iopcb_pkg;
	// Sizes
	localparam int NUM_CB   = 6;
	localparam int XFER_W   = 32;
	localparam int CNT_W    = 16;
	localparam int SIDX_W   = 5;
	localparam int CB_SEL_W = 3;
	localparam int CB_DIV_W = 8;
	localparam int IRQ_W    = 2;
	// Register byte addresses
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_DATA    = 8'h04;
	localparam logic [7:0] A_STAT    = 8'h08;
	localparam logic [7:0] A_COUNT   = 8'h0C;
	localparam logic [7:0] A_TSTAMP  = 8'h10;
	localparam logic [7:0] A_TTIME   = 8'h14;
	localparam logic [7:0] A_COND    = 8'h18;
	localparam logic [7:0] A_IRQ_ST  = 8'h1C;
	localparam logic [7:0] A_IRQ_MSK = 8'h20;
	localparam logic [7:0] A_CB_BASE = 8'h40;
	// Control fields
	localparam int C_EN    = 0;
	localparam int C_OUT   = 1;
	localparam int C_OD    = 2;
	localparam int C_CEN   = 3;
	localparam int C_CNE   = 4;
	localparam int C_SIN   = 5;
	localparam int C_SOUT  = 6;
	localparam int C_SER   = 7;
	localparam int C_CB_LO = 8;
	localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	// Status and interrupt fields
	localparam int S_TXF  = 0;
	localparam int S_RXF  = 1;
	localparam int S_ARM  = 2;
	localparam int I_XFER = 0;
	localparam int I_OVR  = 1;
	// Clock block configuration fields
	localparam int CB_RUN    = 0;
	localparam int CB_EXT    = 1;
	localparam int CB_DIV_LO = 8;
	typedef enum logic [0:0] {XF_IDLE, XF_BUSY} iopcb_xfer_e;
endpackage

// >>> verilog/iopcb_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module iopcb_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/iopcb_clkblk.sv
// One clock block: reference or external pin source, divider, tick.
// Assumes ext_lvl is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module iopcb_clkblk #(
	parameter bit IS_REF = 1'b0
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Source and configuration
	input  wire logic        ext_lvl,
	input  wire logic        wr,
	input  wire logic [31:0] wdata,
	// Results
	output logic             tick,
	output logic      [31:0] cfg
);
	localparam int DW = iopcb_pkg::CB_DIV_W;
	logic          run_ff;
	logic          ext_ff;
	logic          lvl_d_ff;
	logic [DW-1:0] div_ff;
	logic [DW-1:0] dcnt_ff;
	logic          src_evt;

	assign src_evt = ext_ff ? (ext_lvl & ~lvl_d_ff) : 1'b1;
	assign tick    = run_ff & src_evt & (dcnt_ff == div_ff);
	always_comb begin
		cfg = '0;
		cfg[iopcb_pkg::CB_RUN] = run_ff;
		cfg[iopcb_pkg::CB_EXT] = ext_ff;
		cfg[iopcb_pkg::CB_DIV_LO +: DW] = div_ff;
	end

	// The reference block is fixed; source and ratio move only when stopped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_ff <= IS_REF;
			ext_ff <= 1'b0;
			div_ff <= '0;
		end else if (wr && !IS_REF) begin
			run_ff <= wdata[iopcb_pkg::CB_RUN];
			if (!run_ff) begin
				ext_ff <= wdata[iopcb_pkg::CB_EXT];
				div_ff <= wdata[iopcb_pkg::CB_DIV_LO +: DW];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl_d_ff <= 1'b0;
			dcnt_ff  <= '0;
		end else begin
			lvl_d_ff <= ext_lvl;
			if (!run_ff)
				dcnt_ff <= '0;
			else if (src_evt)
				dcnt_ff <= (dcnt_ff == div_ff) ? '0 : dcnt_ff + 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/iopcb_port.sv
// One I/O port with transfer register, serialiser, port counter,
// timestamp and six clock blocks, behind an Avalon-MM slave.
// Assumes pins are asynchronous; link and sharing inputs are on clk.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module iopcb_port #(
	parameter int WIDTH  = 8,
	parameter int NUM_CB = iopcb_pkg::NUM_CB
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Avalon-MM slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Pins
	input  wire logic [WIDTH-1:0]  pin_in,
	output logic      [WIDTH-1:0]  pin_out,
	output logic      [WIDTH-1:0]  pin_oe,
	input  wire logic              input_strobe,
	output logic                   output_strobe,
	input  wire logic [NUM_CB-1:0] cb_clk_pin,
	output logic                   pull_down_en,
	// Pin sharing
	input  wire logic              link_en,
	input  wire logic [WIDTH-1:0]  narrow_taken,
	// Interrupt
	output logic                   irq
);
	localparam int XW     = iopcb_pkg::XFER_W;
	localparam int CW     = iopcb_pkg::CNT_W;
	localparam int SW     = iopcb_pkg::SIDX_W;
	localparam int IW     = iopcb_pkg::IRQ_W;
	localparam int SLICES = XW / WIDTH;
	localparam logic [SW-1:0] LAST = SW'(SLICES - 1);

	default clocking cb_main @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Bus side
	logic                ack_ff;
	logic                req;
	logic                wr;
	logic                rd;
	logic [31:0]         bm;
	logic [31:0]         wmrg;
	logic [7:0]          cb_off;
	logic                cb_hit;
	logic [31:0]         rdat;
	// Registers
	logic [31:0]         ctrl_ff;
	logic [XW-1:0]       xfer_ff;
	logic [XW-1:0]       sh_ff;
	logic [CW-1:0]       count_ff;
	logic [CW-1:0]       tstamp_ff;
	logic [CW-1:0]       ttime_ff;
	logic [WIDTH-1:0]    cond_ff;
	logic [IW-1:0]       ist_ff;
	logic [IW-1:0]       imsk_ff;
	logic                tx_full_ff;
	logic                rx_full_ff;
	logic                arm_ff;
	logic [SW-1:0]       sidx_ff;
	iopcb_pkg::iopcb_xfer_e st_ff;
	// Pins after synchronisers
	logic [WIDTH-1:0]    pin_s;
	logic                istrb_s;
	logic [NUM_CB-1:0]   ext_s;
	// Clock blocks
	logic [NUM_CB-1:0]   cb_tick;
	logic [NUM_CB-1:0]   cb_wr;
	logic [31:0]         cb_cfg [NUM_CB];
	// Engine
	logic [iopcb_pkg::CB_SEL_W-1:0] cb_sel;
	logic                tick;
	logic                en;
	logic                dir_out;
	logic                ser;
	logic                cond_ok;
	logic                timed_ok;
	logic                strb_ok;
	logic                start;
	logic                slice;
	logic                last;
	logic [XW-1:0]       src;
	logic [XW-1:0]       sh_in;
	logic                data_wr;
	logic                tx_ovr;
	logic [IW-1:0]       evt;
	logic [WIDTH-1:0]    nxt_oe;

	// One wait cycle, then the access completes
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_ff;
	assign wr              = avs_write & ack_ff;
	assign rd              = avs_read & ack_ff;
	assign bm     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wmrg   = avs_writedata & bm;
	assign cb_off = avs_address - iopcb_pkg::A_CB_BASE;
	assign cb_hit = (avs_address >= iopcb_pkg::A_CB_BASE) &&
	                (cb_off[7:2] < NUM_CB) && (cb_off[1:0] == 2'h0);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	iopcb_sync #(
		.W(WIDTH + 1 + NUM_CB)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({cb_clk_pin, input_strobe, pin_in}),
		.q      ({ext_s, istrb_s, pin_s})
	);

	// Block zero is the fixed reference; the rest are programmable
	for (genvar i = 0; i < NUM_CB; i++) begin : g_cb
		assign cb_wr[i] = wr && cb_hit && (cb_off[7:2] == i);
		iopcb_clkblk #(
			.IS_REF (i == 0)
		) u_cb (
			.clk    (clk),
			.arst_n (arst_n),
			.ext_lvl(ext_s[i]),
			.wr     (cb_wr[i]),
			.wdata  ((cb_cfg[i] & ~bm) | wmrg),
			.tick   (cb_tick[i]),
			.cfg    (cb_cfg[i])
		);
	end

	// Control fields
	assign cb_sel   = ctrl_ff[iopcb_pkg::C_CB_LO +: iopcb_pkg::CB_SEL_W];
	assign tick     = (cb_sel < NUM_CB) ? cb_tick[cb_sel] : 1'b0;
	assign en       = ctrl_ff[iopcb_pkg::C_EN] & ~link_en;
	assign dir_out  = ctrl_ff[iopcb_pkg::C_OUT];
	assign ser      = ctrl_ff[iopcb_pkg::C_SER];
	assign cond_ok  = ~ctrl_ff[iopcb_pkg::C_CEN] |
	                  ((pin_s == cond_ff) ^ ctrl_ff[iopcb_pkg::C_CNE]);
	assign timed_ok = ~arm_ff | (count_ff == ttime_ff);
	assign strb_ok  = ~ctrl_ff[iopcb_pkg::C_SIN] | istrb_s;
	assign data_wr  = wr && avs_address == iopcb_pkg::A_DATA;
	assign tx_ovr   = data_wr & dir_out & tx_full_ff;

	// Condition (input ports only) and due time gate only the first slice
	assign start = tick & en & strb_ok & (st_ff == iopcb_pkg::XF_IDLE) &
	               timed_ok & (dir_out ? tx_full_ff : cond_ok);
	assign slice = start |
	               (tick & en & strb_ok & (st_ff == iopcb_pkg::XF_BUSY));
	assign last  = slice & (~ser | (sidx_ff == LAST));
	assign src   = (st_ff == iopcb_pkg::XF_IDLE) ? xfer_ff : sh_ff;
	assign sh_in = (sh_ff >> WIDTH) | (XW'(pin_s) << (XW - WIDTH));
	assign evt   = {(~dir_out & last & rx_full_ff) | tx_ovr, last};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff   <= iopcb_pkg::XF_IDLE;
			sidx_ff <= '0;
		end else if (last) begin
			st_ff   <= iopcb_pkg::XF_IDLE;
			sidx_ff <= '0;
		end else if (slice) begin
			st_ff   <= iopcb_pkg::XF_BUSY;
			sidx_ff <= sidx_ff + 1'b1;
		end
	end

	// Serialiser: a slice of WIDTH bits per tick, lsb slice first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_ff   <= '0;
			pin_out <= '0;
		end else if (slice) begin
			if (dir_out) begin
				pin_out <= src[WIDTH-1:0];
				sh_ff   <= src >> WIDTH;
			end else begin
				sh_ff   <= sh_in;
			end
		end
	end

	// Transfer register: software side and pin side
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xfer_ff <= '0;
		end else if (!dir_out && last) begin
			xfer_ff <= ser ? sh_in : XW'(pin_s);
		end else if (data_wr && dir_out && !tx_full_ff) begin
			xfer_ff <= (xfer_ff & ~bm) | wmrg;
		end
	end

	// A fresh word wins over the read that empties the register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_full_ff <= 1'b0;
			rx_full_ff <= 1'b0;
		end else begin
			if (data_wr && dir_out && !tx_full_ff)
				tx_full_ff <= 1'b1;
			else if (dir_out && last)
				tx_full_ff <= 1'b0;
			if (!dir_out && last)
				rx_full_ff <= 1'b1;
			else if (rd && avs_address == iopcb_pkg::A_DATA)
				rx_full_ff <= 1'b0;
		end
	end

	// Port counter and timestamp
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff  <= '0;
			tstamp_ff <= '0;
		end else begin
			if (tick)
				count_ff <= count_ff + 1'b1;
			if (last)
				tstamp_ff <= count_ff;
		end
	end

	// Output strobe stands for one port-clock period per slice
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			output_strobe <= 1'b0;
		else if (tick)
			output_strobe <= slice & dir_out &
			                 ctrl_ff[iopcb_pkg::C_SOUT];
	end

	// Pin drive
	always_comb begin
		nxt_oe = {WIDTH{en & dir_out}} & ~narrow_taken;
		if (ctrl_ff[iopcb_pkg::C_OD])
			nxt_oe = nxt_oe & ~pin_out;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_oe       <= '0;
			pull_down_en <= 1'b1;
		end else begin
			pin_oe       <= nxt_oe;
			pull_down_en <= 1'b0;
		end
	end

	// Software-written registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff  <= iopcb_pkg::CTRL_RST;
			ttime_ff <= '0;
			cond_ff  <= '0;
			imsk_ff  <= '0;
			arm_ff   <= 1'b0;
		end else begin
			if (wr && avs_address == iopcb_pkg::A_CTRL)
				ctrl_ff <= ((ctrl_ff & ~bm) | wmrg) & iopcb_pkg::CTRL_MASK;
			if (wr && avs_address == iopcb_pkg::A_COND)
				cond_ff <= WIDTH'((XW'(cond_ff) & ~bm) | wmrg);
			if (wr && avs_address == iopcb_pkg::A_IRQ_MSK)
				imsk_ff <= IW'((XW'(imsk_ff) & ~bm) | wmrg);
			if (wr && avs_address == iopcb_pkg::A_TTIME) begin
				ttime_ff <= CW'((XW'(ttime_ff) & ~bm) | wmrg);
				arm_ff   <= 1'b1;
			end else if (start) begin
				arm_ff   <= 1'b0;
			end
		end
	end

	// Sticky events, write one to clear; a new event wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ist_ff <= '0;
		else if (wr && avs_address == iopcb_pkg::A_IRQ_ST)
			ist_ff <= (ist_ff & ~wmrg[IW-1:0]) | evt;
		else
			ist_ff <= ist_ff | evt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(ist_ff & imsk_ff);
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdat = '0;
		case (avs_address)
			iopcb_pkg::A_CTRL:    rdat = ctrl_ff;
			iopcb_pkg::A_DATA:    rdat = xfer_ff;
			iopcb_pkg::A_STAT: begin
				rdat[iopcb_pkg::S_TXF] = tx_full_ff;
				rdat[iopcb_pkg::S_RXF] = rx_full_ff;
				rdat[iopcb_pkg::S_ARM] = arm_ff;
			end
			iopcb_pkg::A_COUNT:   rdat = XW'(count_ff);
			iopcb_pkg::A_TSTAMP:  rdat = XW'(tstamp_ff);
			iopcb_pkg::A_TTIME:   rdat = XW'(ttime_ff);
			iopcb_pkg::A_COND:    rdat = XW'(cond_ff);
			iopcb_pkg::A_IRQ_ST:  rdat = XW'(ist_ff);
			iopcb_pkg::A_IRQ_MSK: rdat = XW'(imsk_ff);
			default: begin
				if (cb_hit)
					rdat = cb_cfg[cb_off[4:2]];
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			avs_readdata <= '0;
		else if (req && !ack_ff)
			avs_readdata <= rdat;
	end

	// Checks
	property p_one_wait;
		req && !ack_ff |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("access not answered after one wait cycle");

	property p_od;
		ctrl_ff[iopcb_pkg::C_OD] |=> (pin_oe & $past(pin_out)) == '0;
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven while output is one");

	property p_link_off;
		link_en |-> !last ##1 pin_oe == '0;
	endproperty
	a_link_off: assert property (p_link_off)
		else $error("port active while link owns the pins");

	property p_narrow;
		##1 (pin_oe & $past(narrow_taken)) == '0;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("pin driven that a narrower port owns");

	property p_dir;
		!dir_out |=> pin_oe == '0;
	endproperty
	a_dir: assert property (p_dir)
		else $error("input port drives its pins");

	property p_count;
		tick |=> count_ff == CW'($past(count_ff) + 1'b1);
	endproperty
	a_count: assert property (p_count)
		else $error("counter did not advance on a tick");

	property p_tstamp;
		last |=> tstamp_ff == $past(count_ff);
	endproperty
	a_tstamp: assert property (p_tstamp)
		else $error("timestamp not the counter at transfer");

	property p_timed;
		start && arm_ff |-> count_ff == ttime_ff;
	endproperty
	a_timed: assert property (p_timed)
		else $error("timed transfer started at the wrong count");

	property p_strobe;
		slice && ctrl_ff[iopcb_pkg::C_SIN] |-> istrb_s;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("slice moved without input strobe");

	property p_irq;
		(ist_ff & imsk_ff) != '0 |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing for unmasked event");

	c_out_xfer: cover property (dir_out && last);
	c_in_xfer:  cover property (!dir_out && last && ser);
	c_timed:    cover property (start && arm_ff);
endmodule
`default_nettype wire

// >>> test/iopcb_ext_model.sv
// Pin-side hardware model: drives input pins, strobe and clock pins.
// Assumes one port under test; released pins fall to the pull-down.
`timescale 1ns/1ps
`default_nettype none
module iopcb_ext_model #(
	parameter int W = 8
) (
	// Port side
	input  wire logic [W-1:0]                pin_out,
	input  wire logic [W-1:0]                pin_oe,
	output logic      [W-1:0]                pin_lvl,
	// Lines driven by the far side
	output logic                             input_strobe,
	output logic      [iopcb_pkg::NUM_CB-1:0] cb_clk_pin
);
	logic [W-1:0] drv_val;
	logic         drv_en;
	initial begin
		drv_val = '0;
		drv_en = 1'b0;
		input_strobe = 1'b0;
		cb_clk_pin = '0;
	end
	// Undriven pins read as the pull-down level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : (drv_en & drv_val[i]);
		end
	end
	// Slow pin clock, still between bursts, unrelated phase
	task automatic clk_burst(input int n, input int idx);
		repeat (n) begin
			#370 cb_clk_pin[idx] = 1'b1;
			#370 cb_clk_pin[idx] = 1'b0;
		end
	endtask
	// Data and qualifying strobe from the far side
	task automatic drive(input logic [W-1:0] v, input logic stb);
		drv_val <= v;
		drv_en <= 1'b1;
		input_strobe <= stb;
	endtask
endmodule
`default_nettype wire

// >>> test/iopcb_port_tb.sv
// Self-checking bench for iopcb_port: bus tasks, pin model, queued notes.
// Assumes the one-wait-cycle bus and register map of the design.
`timescale 1ns/1ps
`default_nettype none
module iopcb_port_tb;
	typedef struct packed {
		logic [31:0] v;
		logic [31:0] m;
	} iopcb_note_s;
	logic        clk;
	logic        arst_n;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  pin_lvl;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic        input_strobe;
	logic        output_strobe;
	logic [5:0]  cb_clk_pin;
	logic        pull_down_en;
	logic        link_en;
	logic [7:0]  narrow_taken;
	logic        irq;
	iopcb_note_s rd_q[$];
	logic [7:0]  pin_q[$];
	logic [31:0] rd_last;
	logic [31:0] c0;
	logic [31:0] c1;
	logic [31:0] wv;
	logic [7:0]  rv;
	int          errors;
	int          num_checks;
	int          seed;
	iopcb_port #(.WIDTH(8), .NUM_CB(6)) u_iopcb_port (
		.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
		.input_strobe(input_strobe), .output_strobe(output_strobe),
		.cb_clk_pin(cb_clk_pin), .pull_down_en(pull_down_en),
		.link_en(link_en), .narrow_taken(narrow_taken), .irq(irq));
	iopcb_ext_model #(.W(8)) u_iopcb_ext_model (
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl),
		.input_strobe(input_strobe), .cb_clk_pin(cb_clk_pin));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_rd(input string what, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_pin(input string what, input logic [7:0] e,
			input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] m);
		int n;
		if (!wr)
			rd_q.push_back('{d & m, m});
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd_last = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			print_verdict();
		end else begin
			cmp_rd("wait cycles", 32'd2, n);
		end
	endtask
	// Bounded poll: latency of sharing inputs is not fixed by the note
	task automatic wait_oe(input logic [7:0] e);
		int n;
		n = 0;
		while (pin_oe !== e && n < 8) begin
			@(posedge clk);
			n++;
		end
		cmp_pin("pin_oe", e, pin_oe);
		if (pin_oe !== e)
			print_verdict();
	endtask
	// Values seen here are those that stood just before the edge
	always @(posedge clk) begin : mon
		iopcb_note_s nt;
		if (avs_read && !avs_waitrequest) begin
			nt = rd_q.pop_front();
			if (nt.m != 32'h0)
				cmp_rd("readdata", nt.v, avs_readdata & nt.m);
		end
		if (output_strobe === 1'b1) begin
			if (pin_q.size() == 0)
				cmp_pin("stray output_strobe", 8'h00, 8'h01);
			else
				cmp_pin("pin_out", pin_q.pop_front(), pin_out);
		end
	end
	initial begin
		arst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		link_en = 1'b0;
		narrow_taken = 8'h00;
		errors = 0;
		num_checks = 0;
		seed = 17650;
		repeat (8) @(posedge clk);
		cmp_pin("pull_down_en", 8'h01, {7'h0, pull_down_en});
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_pin("pull_down_en", 8'h00, {7'h0, pull_down_en});
		bus(0, iopcb_pkg::A_CTRL, iopcb_pkg::CTRL_RST, 32'hFFFF_FFFF);
		bus(0, 8'h3C, 32'h0, 32'hFFFF_FFFF);
		$display("test reset done");
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_0043, 0);
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c0 = rd_last;
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c1 = rd_last;
		cmp_rd("count step", 32'd3, (c1 - c0) & 32'hFFFF);
		cmp_rd("count width", 32'h0, c1 & 32'hFFFF_0000);
		$display("test counter done");
		rv = 8'($random(seed));
		bus(1, iopcb_pkg::A_IRQ_MSK, 32'h1, 0);
		pin_q.push_back(rv);
		bus(1, iopcb_pkg::A_DATA, {24'h0, rv}, 0);
		repeat (3) @(posedge clk);
		cmp_pin("pin_oe", 8'hFF, pin_oe);
		cmp_pin("irq", 8'h01, {7'h0, irq});
		bus(0, iopcb_pkg::A_TSTAMP, 0, 0);
		c0 = rd_last;
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c1 = ((rd_last - c0) & 32'hFFFF) inside {[1:12]};
		cmp_rd("timestamp age", 32'h1, c1);
		bus(1, iopcb_pkg::A_IRQ_MSK, 32'h0, 0);
		repeat (2) @(posedge clk);
		cmp_pin("irq masked", 8'h00, {7'h0, irq});
		bus(1, iopcb_pkg::A_IRQ_ST, 32'h1, 0);
		bus(0, iopcb_pkg::A_IRQ_ST, 32'h0, 32'h3);
		$display("test output done");
		// Word waits until the counter reaches the armed time
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c0 = (rd_last + 32'd40) & 32'hFFFF;
		bus(1, iopcb_pkg::A_TTIME, c0, 0);
		pin_q.push_back(~rv);
		bus(1, iopcb_pkg::A_DATA, {24'h0, ~rv}, 0);
		repeat (45) @(posedge clk);
		bus(0, iopcb_pkg::A_TSTAMP, c0, 32'hFFFF_FFFF);
		bus(0, iopcb_pkg::A_STAT, 32'h0, 32'h5);
		$display("test timed done");
		wv = $random(seed);
		for (int i = 0; i < 4; i++)
			pin_q.push_back(wv[8*i +: 8]);
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_00C3, 0);
		bus(1, iopcb_pkg::A_DATA, wv, 0);
		repeat (8) @(posedge clk);
		cmp_pin("slices left", 8'h00, 8'(pin_q.size()));
		$display("test serialise done");
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_0007, 0);
		bus(1, iopcb_pkg::A_DATA, 32'h0000_00F0, 0);
		wait_oe(8'h0F);
		narrow_taken <= 8'h03;
		wait_oe(8'h0C);
		link_en <= 1'b1;
		wait_oe(8'h00);
		link_en <= 1'b0;
		narrow_taken <= 8'h00;
		$display("test sharing done");
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_0021, 0);
		u_iopcb_ext_model.drive(rv, 1'b1);
		repeat (6) @(posedge clk);
		bus(0, iopcb_pkg::A_DATA, {24'h0, rv}, 32'hFFFF_FFFF);
		u_iopcb_ext_model.drive(~rv, 1'b0);
		repeat (6) @(posedge clk);
		bus(0, iopcb_pkg::A_DATA, {24'h0, rv}, 32'hFFFF_FFFF);
		u_iopcb_ext_model.drive(~rv, 1'b1);
		repeat (6) @(posedge clk);
		bus(0, iopcb_pkg::A_DATA, {24'h0, ~rv}, 32'hFFFF_FFFF);
		$display("test input done");
		// Block 1 still stopped, so the first word never leaves
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_0103, 0);
		bus(1, iopcb_pkg::A_IRQ_ST, 32'h3, 0);
		bus(0, iopcb_pkg::A_IRQ_ST, 32'h0, 32'h2);
		bus(1, iopcb_pkg::A_DATA, 32'h1, 0);
		bus(1, iopcb_pkg::A_DATA, 32'h2, 0);
		bus(0, iopcb_pkg::A_STAT, 32'h1, 32'h1);
		bus(0, iopcb_pkg::A_IRQ_ST, 32'h2, 32'h2);
		bus(1, iopcb_pkg::A_IRQ_ST, 32'h3, 0);
		$display("test overrun done");
		bus(1, iopcb_pkg::A_CB_BASE + 8'h04, 32'h0000_0103, 0);
		bus(0, iopcb_pkg::A_CB_BASE + 8'h04, 32'h103, 32'hFF03);
		bus(1, iopcb_pkg::A_CB_BASE + 8'h04, 32'h0000_0503, 0);
		bus(0, iopcb_pkg::A_CB_BASE + 8'h04, 32'h103, 32'hFF03);
		bus(1, iopcb_pkg::A_CTRL, 32'h0000_0101, 0);
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c0 = rd_last;
		u_iopcb_ext_model.clk_burst(6, 1);
		repeat (4) @(posedge clk);
		bus(0, iopcb_pkg::A_COUNT, 0, 0);
		c1 = rd_last;
		cmp_rd("ext count", 32'd3, (c1 - c0) & 32'hFFFF);
		$display("test clock block done");
		print_verdict();
	end
endmodule
`default_nettype wire
